// [bench/tb.sv]
`timescale 1ns/100ps
module tb;
	localparam int FP = 20;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ref_bad = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic [31:0] rdata;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [7:0] level;
	logic [7:0] sz;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	int seed = 32'h015f;
	int g;
	always #25 aclk = ~aclk;
	lbk_leaky_bucket #(.FILL_PERIOD(FP)) uut (
		.aclk(aclk), .aresetn(aresetn), .ref_bad(ref_bad),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .bucket_level(level), .irq(irq)
	);
	task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// one leak per period of 1, 2, 4 or 8 fill cycles
	function automatic int exp_gap(int s);
		return FP * (1 << s);
	endfunction
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// bound is more than twenty times the whole planned run
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			give_verdict;
		end
	end
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", bresp, lbk_pkg::RESP_OKAY);
	endtask
	task automatic rchk(string n, logic [7:0] a, logic [31:0] e, logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk(n, rdata, e);
		chk("rresp", rresp, er);
	endtask
	task automatic wait_chg;
		logic [7:0] v;
		v = level;
		for (int i = 0; i < 400 && level === v; i++) @(posedge aclk);
	endtask
	// first change may come part way through a period, so time the next one
	task automatic gap(output int d);
		realtime t0;
		wait_chg;
		t0 = $realtime;
		wait_chg;
		d = int'(($realtime - t0) / 50.0);
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("leak_rst", lbk_pkg::ADDR_LEAK_CFG, 32'h1, 2'h0);
		rchk("size_rst", lbk_pkg::ADDR_SIZE_CFG, 32'h8, 2'h0);
		rchk("unmapped", 8'h14, 32'h0, lbk_pkg::RESP_SLVERR);
		wr(lbk_pkg::ADDR_LEAK_CFG, 32'hFF);
		rchk("leak_unused", lbk_pkg::ADDR_LEAK_CFG, 32'h3, 2'h0);
		$display("end registers");
		sz = 8'(3 + ($random(seed) & 3));
		wr(lbk_pkg::ADDR_SIZE_CFG, {24'h0, sz});
		wr(lbk_pkg::ADDR_IRQ_MASK, 32'h3);
		ref_bad <= 1'b1;
		gap(g);
		chk("fill_gap", g, FP);
		repeat (FP * (sz + 3)) @(posedge aclk);
		chk("cap", level, sz);
		chk("irq_on", irq, 1'b1);
		rchk("level_reg", lbk_pkg::ADDR_LEVEL, {24'h0, sz}, 2'h0);
		ref_bad <= 1'b0;
		// let the last bad fill cycle close so no event lands after the clear
		repeat (FP * 2) @(posedge aclk);
		chk("irq_held", irq, 1'b1);
		wr(lbk_pkg::ADDR_IRQ_MASK, 32'h0);
		rchk("stat_bits", lbk_pkg::ADDR_IRQ_STAT, 32'h3, 2'h0);
		rchk("stat_clr", lbk_pkg::ADDR_IRQ_STAT, 32'h0, 2'h0);
		repeat (3) @(posedge aclk);
		chk("irq_off", irq, 1'b0);
		$display("end fill");
		for (int s = 0; s < 4; s++) begin
			wr(lbk_pkg::ADDR_LEAK_CFG, 32'(s));
			ref_bad <= 1'b1;
			repeat (FP * (sz + 2)) @(posedge aclk);
			ref_bad <= 1'b0;
			gap(g);
			chk("decay_gap", g, exp_gap(s));
		end
		$display("end decay");
		wr(lbk_pkg::ADDR_LEAK_CFG, 32'h0);
		repeat (FP * 12) @(posedge aclk);
		chk("floor", level, 8'h00);
		rchk("floor_reg", lbk_pkg::ADDR_LEVEL, 32'h0, 2'h0);
		$display("end floor");
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("leak_rst2", lbk_pkg::ADDR_LEAK_CFG, 32'h1, 2'h0);
		rchk("size_rst2", lbk_pkg::ADDR_SIZE_CFG, 32'h8, 2'h0);
		chk("level_rst2", level, 8'h00);
		$display("end reset");
		give_verdict;
	end
endmodule

// [src/lbk_leaky_bucket.sv]
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
// Notes on behaviour
// - bad fill cycle adds one to accumulator
// - clean decay period subtracts one
// - select 00..11 gives 128..1024 ms period
// - shortest period equals one fill cycle
// - accumulator capped at programmable size, default eight
module lbk_leaky_bucket #(
	parameter int FILL_PERIOD = int'(lbk_pkg::FILL_CYCLES)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ref_bad,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [7:0] bucket_level,
	output logic irq
);
	// ref_bad is asynchronous; two stages before use
	logic bad_s1_q, bad_s2_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bad_s1_q <= 1'b0;
			bad_s2_q <= 1'b0;
		end else begin
			bad_s1_q <= ref_bad;
			bad_s2_q <= bad_s1_q;
		end
	end

	// fill cycle timer and bucket state
	logic [31:0] tick_q, tick_d;
	logic seen_q, seen_d;
	logic [2:0] dcnt_q, dcnt_d;
	logic dirty_q, dirty_d;
	logic [7:0] acc_q, acc_d;
	logic fill_end;
	logic [2:0] dlast;
	lbk_pkg::lbk_cfg_s cfg_q, cfg_d;
	logic ev_fill, ev_full;

	assign fill_end = (tick_q == 32'(FILL_PERIOD - 1));
	// period in fill cycles is 1<<sel, so last index is (1<<sel)-1
	assign dlast = 3'((4'h1 << cfg_q.leak_sel) - 4'h1);

	always_comb begin
		tick_d = fill_end ? 32'h0 : tick_q + 32'h1;
		seen_d = fill_end ? 1'b0 : (seen_q | bad_s2_q);
		dcnt_d = dcnt_q;
		dirty_d = dirty_q;
		acc_d = acc_q;
		ev_fill = 1'b0;
		ev_full = 1'b0;
		if (fill_end) begin
			if (seen_q | bad_s2_q) begin
				if (acc_q < cfg_q.size_max) begin
					acc_d = acc_q + 8'h1;
					ev_fill = 1'b1;
				end else begin
					acc_d = cfg_q.size_max;
					ev_full = 1'b1;
				end
			end
			// a bad fill cycle spoils the current decay period
			if (dcnt_q >= dlast) begin
				dcnt_d = 3'h0;
				dirty_d = 1'b0;
				if (!(dirty_q | seen_q | bad_s2_q) && acc_q != 8'h0) begin
					acc_d = acc_q - 8'h1;
				end
			end else begin
				dcnt_d = dcnt_q + 3'h1;
				dirty_d = dirty_q | seen_q | bad_s2_q;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_q <= 32'h0;
			seen_q <= 1'b0;
			dcnt_q <= 3'h0;
			dirty_q <= 1'b0;
			acc_q <= 8'h0;
		end else begin
			tick_q <= tick_d;
			seen_q <= seen_d;
			dcnt_q <= dcnt_d;
			dirty_q <= dirty_d;
			acc_q <= acc_d;
		end
	end

	// axi-lite slave; both addr and data must be held before the write lands
	logic aw_h_q, aw_h_d, w_h_q, w_h_d;
	logic [7:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d;
	logic [3:0] ws_q, ws_d;
	logic bv_q, bv_d, rv_q, rv_d;
	logic [1:0] br_q, br_d, rr_q, rr_d;
	logic [31:0] rd_q, rd_d;
	logic [1:0] st_q, st_d, msk_q, msk_d;
	logic irq_q, irq_d;
	// readys registered from next state so every port leaves a flop
	logic aw_rdy_q, w_rdy_q, ar_rdy_q;
	logic do_wr, do_rd;

	function automatic logic addr_ok(input logic [7:0] a);
		return a == lbk_pkg::ADDR_LEAK_CFG || a == lbk_pkg::ADDR_SIZE_CFG
			|| a == lbk_pkg::ADDR_LEVEL || a == lbk_pkg::ADDR_IRQ_STAT
			|| a == lbk_pkg::ADDR_IRQ_MASK;
	endfunction

	assign do_wr = aw_h_q && w_h_q && !bv_q;
	assign do_rd = s_axi_arvalid && !rv_q;

	always_comb begin
		aw_h_d = aw_h_q;
		w_h_d = w_h_q;
		awa_d = awa_q;
		wd_d = wd_q;
		ws_d = ws_q;
		bv_d = bv_q;
		br_d = br_q;
		rv_d = rv_q;
		rr_d = rr_q;
		rd_d = rd_q;
		cfg_d = cfg_q;
		msk_d = msk_q;
		st_d = st_q;
		if (s_axi_awvalid && !aw_h_q) begin
			aw_h_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_h_q) begin
			w_h_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		if (bv_q && s_axi_bready) begin
			bv_d = 1'b0;
		end
		if (do_wr) begin
			aw_h_d = 1'b0;
			w_h_d = 1'b0;
			bv_d = 1'b1;
			br_d = addr_ok(awa_q) ? lbk_pkg::RESP_OKAY : lbk_pkg::RESP_SLVERR;
			if (ws_q[0]) begin
				if (awa_q == lbk_pkg::ADDR_LEAK_CFG) begin
					cfg_d.leak_sel = wd_q[lbk_pkg::LEAK_SEL_LSB +: lbk_pkg::LEAK_SEL_W];
				end
				if (awa_q == lbk_pkg::ADDR_SIZE_CFG) begin
					cfg_d.size_max = wd_q[7:0];
				end
				if (awa_q == lbk_pkg::ADDR_IRQ_MASK) begin
					msk_d = wd_q[1:0];
				end
			end
		end
		if (rv_q && s_axi_rready) begin
			rv_d = 1'b0;
		end
		if (do_rd) begin
			rv_d = 1'b1;
			rr_d = addr_ok(s_axi_araddr) ? lbk_pkg::RESP_OKAY : lbk_pkg::RESP_SLVERR;
			unique case (s_axi_araddr)
				// bits 7:2 of the leak config read as zero
				lbk_pkg::ADDR_LEAK_CFG: rd_d = {30'h0, cfg_q.leak_sel};
				lbk_pkg::ADDR_SIZE_CFG: rd_d = {24'h0, cfg_q.size_max};
				lbk_pkg::ADDR_LEVEL: rd_d = {24'h0, acc_q};
				lbk_pkg::ADDR_IRQ_STAT: rd_d = {30'h0, st_q};
				lbk_pkg::ADDR_IRQ_MASK: rd_d = {30'h0, msk_q};
				default: rd_d = 32'h0;
			endcase
			if (s_axi_araddr == lbk_pkg::ADDR_IRQ_STAT) begin
				st_d = 2'h0;
			end
		end
		// set beats the read-clear
		if (ev_fill) begin
			st_d[lbk_pkg::IRQ_FILL_BIT] = 1'b1;
		end
		if (ev_full) begin
			st_d[lbk_pkg::IRQ_FULL_BIT] = 1'b1;
		end
		irq_d = |(st_d & msk_d);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_h_q <= 1'b0;
			w_h_q <= 1'b0;
			awa_q <= 8'h0;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			bv_q <= 1'b0;
			br_q <= lbk_pkg::RESP_OKAY;
			rv_q <= 1'b0;
			rr_q <= lbk_pkg::RESP_OKAY;
			rd_q <= 32'h0;
			cfg_q.leak_sel <= lbk_pkg::LEAK_CFG_RST[1:0];
			cfg_q.size_max <= lbk_pkg::SIZE_CFG_RST;
			msk_q <= lbk_pkg::IRQ_MASK_RST;
			st_q <= 2'h0;
			irq_q <= 1'b0;
			aw_rdy_q <= 1'b1;
			w_rdy_q <= 1'b1;
			ar_rdy_q <= 1'b1;
		end else begin
			aw_h_q <= aw_h_d;
			w_h_q <= w_h_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			bv_q <= bv_d;
			br_q <= br_d;
			rv_q <= rv_d;
			rr_q <= rr_d;
			rd_q <= rd_d;
			cfg_q <= cfg_d;
			msk_q <= msk_d;
			st_q <= st_d;
			irq_q <= irq_d;
			aw_rdy_q <= !aw_h_d;
			w_rdy_q <= !w_h_d;
			ar_rdy_q <= !rv_d;
		end
	end

	// level output registered again so it comes from a flip-flop
	logic [7:0] lvl_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_q <= 8'h0;
		end else begin
			lvl_q <= acc_q;
		end
	end

	assign s_axi_awready = aw_rdy_q;
	assign s_axi_wready = w_rdy_q;
	assign s_axi_bvalid = bv_q;
	assign s_axi_bresp = br_q;
	assign s_axi_arready = ar_rdy_q;
	assign s_axi_rvalid = rv_q;
	assign s_axi_rresp = rr_q;
	assign s_axi_rdata = rd_q;
	assign bucket_level = lvl_q;
	assign irq = irq_q;

	a_acc_bounded: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(acc_q) && $past(fill_end)
		|-> acc_q <= $past(cfg_q.size_max) || acc_q < $past(acc_q))
		else $error("accumulator rose above size");
	a_no_underflow: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(acc_q) == 8'h0 |-> acc_q <= 8'h1)
		else $error("accumulator wrapped below zero");
	a_fill_step: assert property (@(posedge aclk) disable iff (!aresetn)
		fill_end && bad_s2_q && acc_q < cfg_q.size_max |=> acc_q == $past(acc_q) + 8'h1)
		else $error("bad fill cycle did not add one");
	a_quiet_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!fill_end |=> acc_q == $past(acc_q))
		else $error("accumulator moved outside fill end");
	a_leak_step: assert property (@(posedge aclk) disable iff (!aresetn)
		fill_end && !(dirty_q | seen_q | bad_s2_q) && dcnt_q >= dlast && acc_q != 8'h0
		|=> acc_q == $past(acc_q) - 8'h1)
		else $error("clean period did not leak");
	a_period_len: assert property (@(posedge aclk) disable iff (!aresetn)
		dlast == ((cfg_q.leak_sel == 2'h0) ? 3'h0 : (cfg_q.leak_sel == 2'h1) ? 3'h1
			: (cfg_q.leak_sel == 2'h2) ? 3'h3 : 3'h7))
		else $error("decay period length wrong");
	a_fast_leak: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_q.leak_sel == 2'h0 && fill_end |=> dcnt_q == 3'h0 && !dirty_q)
		else $error("shortest period not one fill cycle");
	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_q == |(st_q & msk_q))
		else $error("interrupt does not follow status");
	// set must survive a read-clear in the same cycle
	a_fill_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		ev_fill |=> st_q[lbk_pkg::IRQ_FILL_BIT])
		else $error("fill event lost from status");
	a_full_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		ev_full |=> st_q[lbk_pkg::IRQ_FULL_BIT])
		else $error("full event lost from status");
	a_stat_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		do_rd && s_axi_araddr == lbk_pkg::ADDR_IRQ_STAT && !ev_fill && !ev_full |=> st_q == 2'h0)
		else $error("status read did not clear");
	a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		bv_q && !s_axi_bready |=> bv_q && $stable(br_q))
		else $error("write response dropped early");
	a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		rv_q && !s_axi_rready |=> rv_q && $stable(rd_q) && $stable(rr_q))
		else $error("read data dropped early");
	a_cfg_reset: assert property (@(posedge aclk)
		!aresetn |=> cfg_q.leak_sel == 2'h1 && cfg_q.size_max == 8'h08)
		else $error("config reset value wrong");
endmodule

// [src/lbk_pkg.sv]
package lbk_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_LEAK_CFG = 8'h00;
	localparam logic [7:0] ADDR_SIZE_CFG = 8'h04;
	localparam logic [7:0] ADDR_LEVEL = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
	// reset values
	localparam logic [7:0] LEAK_CFG_RST = 8'h01;
	localparam logic [7:0] SIZE_CFG_RST = 8'h08;
	localparam logic [1:0] IRQ_MASK_RST = 2'h0;
	// field positions
	localparam int LEAK_SEL_LSB = 0;
	localparam int LEAK_SEL_W = 2;
	localparam int IRQ_FILL_BIT = 0;
	localparam int IRQ_FULL_BIT = 1;
	// timing: one fill cycle
	localparam int CLK_HZ = 20000000;
	localparam int FILL_MS = 128;
	localparam longint FILL_CYCLES = (longint'(CLK_HZ) * FILL_MS) / 1000;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] leak_sel;
		logic [7:0] size_max;
	} lbk_cfg_s;
endpackage
